// file: design/homing_jog_defs.vh
// Constants for the homing and jog speed table control block
//******************************************************************
//******************************************************************
`ifndef HOMING_JOG_DEFS_VH
`define HOMING_JOG_DEFS_VH
`define POL_ON 2'h0
`define POL_OFF 2'h1
`define POL_FORCE_ON 2'h2
`define POL_FORCE_OFF 2'h3
`define METHOD_NONE 2'h0
`define METHOD_DEC_C 2'h1
`define METHOD_DEC 2'h2
`define METHOD_C 2'h3
`define SPEED_DEFAULT 27'h000_03e8
`define SPEED_MIN 27'h000_0001
`define SPEED_MAX 27'h5f5_e0ff
`define POS_MAX 28'h5f5_e0ff
// Register offsets of the software port
`define REG_CFG0 6'h00
`define REG_CFG1 6'h01
`define REG_HOME_POS 6'h02
`define REG_ACCEL 6'h03
`define REG_DECEL 6'h04
`define REG_STATUS 6'h05
`define REG_CMD 6'h06
`define REG_NV_STATUS 6'h07
`define REG_JOG_BASE 6'h10
// Command bits
`define CMD_RESET 0
`define CMD_STORE 1
`define CMD_HOME_DONE 2
`endif

// file: design/homing_jog_speed_table_control.v
// Homing and jog speed table mode control logic
//
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "homing_jog_defs.vh"

module homing_jog_speed_table_control #(
  parameter SPEED_W = 27,
  parameter POS_W = 28,
  parameter RATE_W = 32
) (
  input wire I_SYS_CLK,
  input wire I_SRST,
  input wire [5:0] i_ADDR,
  input wire [31:0] i_WDATA,
  input wire i_WR,
  input wire i_RD,
  output reg [31:0] o_RDATA,
  input wire i_MODE_OPTO,
  input wire i_HOME_OPTO,
  input wire i_DECEL_OPTO,
  input wire i_JOG_FWD_OPTO,
  input wire i_JOG_REV_OPTO,
  input wire [3:0] i_SPEED_SEL_OPTO,
  input wire i_PHASE_C,
  input wire [4:0] i_ZONE_SIGNALS,
  input wire i_NV_DONE,
  output reg [4:0] o_PROG_OUTPUTS,
  output reg o_MODE1,
  output reg o_HOMING_RUN,
  output reg o_HOMING_DIR_REV,
  output reg o_HOMING_HALTED,
  output reg o_HOMING_DONE,
  output reg [1:0] o_HOMING_STEP,
  output reg [RATE_W-1:0] o_HOMING_RATE,
  output reg o_POS_LOAD,
  output reg [POS_W-1:0] o_POS_LOAD_VALUE,
  output reg o_JOG_FWD,
  output reg o_JOG_REV,
  output reg [SPEED_W-1:0] o_JOG_SPEED,
  output reg o_NV_STORE,
  output reg [SPEED_W*16-1:0] o_NV_DATA
);

  //******************************************************************
  // Homing step codes
  //******************************************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_SEEK = 2'h1;
  localparam ST_CREEP = 2'h2;
  localparam ST_FINAL = 2'h3;

  //******************************************************************
  // Functions
  //******************************************************************
  // Polarity and forcing decode of one synchronised opto level
  function decode_input;
    input [1:0] pol;
    input level;
    begin
      case (pol)
        `POL_ON: decode_input = level;
        `POL_OFF: decode_input = ~level;
        `POL_FORCE_ON: decode_input = 1'b1;
        default: decode_input = 1'b0;
      endcase
    end
  endfunction

  // Clamp a written speed into the legal entry range
  function [SPEED_W-1:0] clamp_speed;
    input [31:0] v;
    begin
      if (v < {5'h00, `SPEED_MIN})
        clamp_speed = `SPEED_MIN;
      else if (v > {5'h00, `SPEED_MAX})
        clamp_speed = `SPEED_MAX;
      else
        clamp_speed = v[SPEED_W-1:0];
    end
  endfunction

  //******************************************************************
  // Configuration storage
  //******************************************************************
  // Output start-up choice and input polarity settings
  reg zone_initial_output_setting;
  reg [1:0] mode_input_polarity;
  reg [1:0] home_input_polarity;
  reg [1:0] decel_input_polarity;
  reg [1:0] jog_forward_polarity;
  reg [1:0] jog_reverse_polarity;
  reg [7:0] speed_select_polarity;
  // Homing reference, direction, position and ramp rates
  reg [1:0] homing_method_setting;
  reg homing_direction_setting;
  reg [POS_W-1:0] home_position_value;
  reg [RATE_W-1:0] accel_rate_setting;
  reg [RATE_W-1:0] decel_rate_setting;
  // Working jog table; edits are lost at power-down until stored
  reg [SPEED_W-1:0] jog_speed_entry [0:15];
  reg table_dirty;
  reg reset_command;
  // Loop indices kept apart so each has a single process
  integer k;
  integer j;

  // Write strobes decoded once for both register processes
  wire wr_jog = i_WR && (i_ADDR[5:4] == 2'h1);
  wire cmd_wr = i_WR && (i_ADDR == `REG_CMD);

  // Register writes and the software reset command
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      zone_initial_output_setting <= 1'b0;
      mode_input_polarity <= `POL_ON;
      home_input_polarity <= `POL_ON;
      decel_input_polarity <= `POL_ON;
      jog_forward_polarity <= `POL_ON;
      jog_reverse_polarity <= `POL_ON;
      speed_select_polarity <= 8'h00;
      homing_method_setting <= `METHOD_NONE;
      homing_direction_setting <= 1'b0;
      home_position_value <= {POS_W{1'b0}};
      accel_rate_setting <= {RATE_W{1'b0}};
      decel_rate_setting <= {RATE_W{1'b0}};
      reset_command <= 1'b0;
      for (k = 0; k < 16; k = k + 1)
        jog_speed_entry[k] <= `SPEED_DEFAULT;
    end else begin
      // Reset command lasts one cycle and restarts the homing state only
      reset_command <= cmd_wr && i_WDATA[`CMD_RESET];
      if (i_WR) begin
        case (i_ADDR)
          `REG_CFG0: begin
            zone_initial_output_setting <= i_WDATA[0];
            mode_input_polarity <= i_WDATA[3:2];
            home_input_polarity <= i_WDATA[5:4];
            decel_input_polarity <= i_WDATA[7:6];
            jog_forward_polarity <= i_WDATA[9:8];
            jog_reverse_polarity <= i_WDATA[11:10];
            speed_select_polarity <= i_WDATA[19:12];
          end
          `REG_CFG1: begin
            homing_method_setting <= i_WDATA[1:0];
            homing_direction_setting <= i_WDATA[2];
          end
          `REG_HOME_POS: home_position_value <= i_WDATA[POS_W-1:0];
          `REG_ACCEL: accel_rate_setting <= i_WDATA;
          `REG_DECEL: decel_rate_setting <= i_WDATA;
          default: ;
        endcase
        // Out-of-range speeds are clamped rather than dropped
        if (wr_jog)
          jog_speed_entry[i_ADDR[3:0]] <= clamp_speed(i_WDATA);
      end
    end
  end

  //******************************************************************
  // Nonvolatile store of the jog table
  //******************************************************************
  // Edits stay volatile until a store snapshots the table out
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_NV_STORE <= 1'b0;
      o_NV_DATA <= {(SPEED_W*16){1'b0}};
      table_dirty <= 1'b0;
    end else begin
      o_NV_STORE <= cmd_wr && i_WDATA[`CMD_STORE];
      // Snapshot holds the table as it stood before this cycle's writes
      if (cmd_wr && i_WDATA[`CMD_STORE]) begin
        for (j = 0; j < 16; j = j + 1)
          o_NV_DATA[j*SPEED_W +: SPEED_W] <= jog_speed_entry[j];
      end
      // An edit in the done cycle keeps the table marked dirty
      if (wr_jog)
        table_dirty <= 1'b1;
      else if (i_NV_DONE)
        table_dirty <= 1'b0;
    end
  end

  //******************************************************************
  // Input synchronisers
  //******************************************************************
  // Bit order: mode, home, decel, forward, reverse, speed selects 0 to 3
  reg [8:0] sync_a;
  reg [8:0] sync_b;
  reg phase_c_d;

  // Two flops per opto input before any decode
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
    end else begin
      sync_a <= {i_SPEED_SEL_OPTO, i_JOG_REV_OPTO, i_JOG_FWD_OPTO, i_DECEL_OPTO,
                 i_HOME_OPTO, i_MODE_OPTO};
      sync_b <= sync_a;
    end
  end

  //******************************************************************
  // Input decode
  //******************************************************************
  // Active levels after polarity and forcing
  wire mode_active;
  wire home_act = decode_input(home_input_polarity, sync_b[1]);
  wire decel_act = decode_input(decel_input_polarity, sync_b[2]);
  wire fwd_act = decode_input(jog_forward_polarity, sync_b[3]);
  wire rev_act = decode_input(jog_reverse_polarity, sync_b[4]);
  wire [3:0] sel;
  // One decode per speed select bit; bit 3 is the most significant
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : sel_dec
      assign sel[g] = decode_input(speed_select_polarity[2*g +: 2], sync_b[5+g]);
    end
  endgenerate

  // Mode input is active in mode 0, so mode 1 is its inactive state
  assign mode_active = (mode_input_polarity == `POL_FORCE_ON) ? 1'b1 :
                       (mode_input_polarity == `POL_FORCE_OFF) ? 1'b0 :
                       (mode_input_polarity == `POL_ON) ? sync_b[0] :
                       ~sync_b[0];
  wire mode1 = ~mode_active;

  // Exactly one request
  wire only_home = home_act && !fwd_act && !rev_act;
  wire only_fwd = !home_act && fwd_act && !rev_act;
  wire only_rev = !home_act && !fwd_act && rev_act;

  //******************************************************************
  // Homing sequencer
  //******************************************************************
  // Sequencer step, halt flag, done flag and edge history
  reg [1:0] step;
  reg halted;
  reg done;
  reg mode1_d;
  reg home_d;
  // References that the chosen method waits for
  wire use_dec = (homing_method_setting == `METHOD_DEC_C) ||
                 (homing_method_setting == `METHOD_DEC);
  wire use_c = (homing_method_setting == `METHOD_DEC_C) ||
               (homing_method_setting == `METHOD_C);
  // Homing may move only in mode 1 with the home request alone
  wire go = mode1 && only_home;
  // Last step of the chosen method is reached
  wire finish = go && (step == ST_FINAL || (step == ST_CREEP && !use_c) ||
                (step == ST_SEEK && !use_dec && phase_c_d));
  // Power-on reset and the reset command both clear the sequence
  wire rst_home = I_SRST || reset_command;

  // Seek decel, creep to phase C, then finish and load position
  always @(posedge I_SYS_CLK) begin
    if (rst_home) begin
      step <= ST_IDLE;
      halted <= 1'b0;
      done <= 1'b0;
      mode1_d <= 1'b0;
      home_d <= 1'b0;
      phase_c_d <= 1'b0;
      o_POS_LOAD <= 1'b0;
      o_POS_LOAD_VALUE <= {POS_W{1'b0}};
    end else begin
      mode1_d <= mode1;
      home_d <= home_act;
      phase_c_d <= i_PHASE_C;
      o_POS_LOAD <= 1'b0;
      // No method: homing counts as complete and never moves
      if (homing_method_setting == `METHOD_NONE) begin
        done <= 1'b1;
        step <= ST_IDLE;
        halted <= 1'b0;
      end else if (step == ST_IDLE) begin
        if (go && home_act && !home_d) begin
          step <= use_dec ? ST_SEEK : ST_CREEP;
          done <= 1'b0;
        end
      end else if (halted) begin
        // A jog request or a mode switch drops the halted sequence
        if (fwd_act || rev_act || (mode1 != mode1_d)) begin
          step <= ST_IDLE;
          halted <= 1'b0;
        end else if (go)
          halted <= 1'b0;
      end else if (!go) begin
        // Any other input combination freezes the current step
        halted <= 1'b1;
      end else if (finish) begin
        // Sequence complete: report done and load the home position
        step <= ST_IDLE;
        done <= 1'b1;
        o_POS_LOAD <= 1'b1;
        o_POS_LOAD_VALUE <= home_position_value;
      end else if (step == ST_SEEK && decel_act) begin
        step <= ST_CREEP;
      end else if (step == ST_CREEP && use_c && phase_c_d) begin
        step <= ST_FINAL;
      end
    end
  end

  //******************************************************************
  // Outputs
  //******************************************************************
  // Registered motion commands, speed lookup and outputs
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_PROG_OUTPUTS <= 5'h00;
      o_MODE1 <= 1'b0;
      o_HOMING_RUN <= 1'b0;
      o_HOMING_DIR_REV <= 1'b0;
      o_HOMING_HALTED <= 1'b0;
      o_HOMING_DONE <= 1'b0;
      o_HOMING_STEP <= ST_IDLE;
      o_HOMING_RATE <= {RATE_W{1'b0}};
      o_JOG_FWD <= 1'b0;
      o_JOG_REV <= 1'b0;
      o_JOG_SPEED <= `SPEED_DEFAULT;
    end else begin
      o_PROG_OUTPUTS <= zone_initial_output_setting ? i_ZONE_SIGNALS : 5'h00;
      o_MODE1 <= mode1;
      o_HOMING_RUN <= (step != ST_IDLE) && !halted && go;
      o_HOMING_DIR_REV <= homing_direction_setting;
      o_HOMING_HALTED <= halted;
      o_HOMING_DONE <= done;
      o_HOMING_STEP <= step;
      // Homing ramps use the gentler of the two rates
      o_HOMING_RATE <= (accel_rate_setting < decel_rate_setting) ?
                       accel_rate_setting : decel_rate_setting;
      // Jog only while its own request is the only one active
      o_JOG_FWD <= mode1 && only_fwd;
      o_JOG_REV <= mode1 && only_rev;
      o_JOG_SPEED <= jog_speed_entry[sel];
    end
  end

  //******************************************************************
  // Register read port
  //******************************************************************
  // Read data stand one cycle after the read strobe
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_RDATA <= 32'h0000_0000;
    end else if (i_RD) begin
      // Jog table entries occupy the sixteen offsets 0x10 to 0x1f
      if (i_ADDR[5:4] == 2'h1)
        o_RDATA <= {{(32-SPEED_W){1'b0}}, jog_speed_entry[i_ADDR[3:0]]};
      else begin
        case (i_ADDR)
          `REG_CFG0: o_RDATA <= {12'h000, speed_select_polarity, jog_reverse_polarity,
                                jog_forward_polarity, decel_input_polarity,
                                home_input_polarity, mode_input_polarity, 1'b0,
                                zone_initial_output_setting};
          `REG_CFG1: o_RDATA <= {29'h0000_0000, homing_direction_setting,
                                homing_method_setting};
          `REG_HOME_POS: o_RDATA <= {{(32-POS_W){1'b0}}, home_position_value};
          `REG_ACCEL: o_RDATA <= accel_rate_setting;
          `REG_DECEL: o_RDATA <= decel_rate_setting;
          `REG_STATUS: o_RDATA <= {19'h0_0000, sel, step, halted, done, only_rev,
                                  only_fwd, only_home, decel_act, mode1};
          `REG_NV_STATUS: o_RDATA <= {31'h0000_0000, table_dirty};
          // Unmapped offsets read as zero
          default: o_RDATA <= 32'h0000_0000;
        endcase
      end
    end else begin
      // Read data stand for one cycle only
      o_RDATA <= 32'h0000_0000;
    end
  end

endmodule // homing_jog_speed_table_control

// file: verification/homing_jog_monitor.sv
// Checker for the homing and jog speed table control outputs
`timescale 1ns/1ps
`include "homing_jog_defs.vh"
module homing_jog_monitor #(
  parameter POS_W = 28,
  parameter RATE_W = 32
) (
  input wire I_SYS_CLK,
  input wire I_SRST,
  input wire [5:0] i_ADDR,
  input wire [31:0] i_WDATA,
  input wire i_WR,
  input wire [4:0] o_PROG_OUTPUTS,
  input wire o_MODE1,
  input wire o_HOMING_RUN,
  input wire o_HOMING_DIR_REV,
  input wire o_HOMING_HALTED,
  input wire [RATE_W-1:0] o_HOMING_RATE,
  input wire o_POS_LOAD,
  input wire [POS_W-1:0] o_POS_LOAD_VALUE,
  input wire o_JOG_FWD,
  input wire o_JOG_REV,
  input wire o_NV_STORE
);
  logic z;
  logic d;
  logic [1:0] m;
  logic [RATE_W-1:0] acc;
  logic [RATE_W-1:0] dec;
  logic [POS_W-1:0] hp;
  // Shadow the settings written over the software port
  always @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      z <= 1'b0;
      d <= 1'b0;
      m <= 2'h0;
      acc <= '0;
      dec <= '0;
      hp <= '0;
    end else if (i_WR) begin
      case (i_ADDR)
        `REG_CFG0: begin
          z <= i_WDATA[0];
          m <= i_WDATA[3:2];
        end
        `REG_CFG1: d <= i_WDATA[2];
        `REG_HOME_POS: hp <= i_WDATA[POS_W-1:0];
        `REG_ACCEL: acc <= i_WDATA[RATE_W-1:0];
        `REG_DECEL: dec <= i_WDATA[RATE_W-1:0];
        default: ;
      endcase
    end
  end
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  a_zone_idle:
    assert property (!z && !$past(z) && !$past(z, 2) |-> o_PROG_OUTPUTS == 5'h00)
      else $error("programmable outputs active with zone start off");
  a_mode_forced:
    assert property (m[1] && $past(m, 3) == m |-> o_MODE1 == m[0])
      else $error("forced mode setting not obeyed");
  a_load_value:
    assert property (o_POS_LOAD |-> o_POS_LOAD_VALUE == $past(hp))
      else $error("position load value differs from home position");
  a_load_pulse:
    assert property (o_POS_LOAD |=> !o_POS_LOAD)
      else $error("position load longer than one cycle");
  a_rate_lesser:
    assert property (o_HOMING_RUN |->
      o_HOMING_RATE == (($past(acc) < $past(dec)) ? $past(acc) : $past(dec)))
      else $error("homing rate is not the lesser rate");
  a_dir_setting:
    assert property (o_HOMING_RUN |-> o_HOMING_DIR_REV == $past(d))
      else $error("homing direction differs from setting");
  a_halt_run:
    assert property (o_HOMING_HALTED |-> !o_HOMING_RUN)
      else $error("homing runs while halted");
  a_one_motion:
    assert property ($onehot0({o_HOMING_RUN, o_JOG_FWD, o_JOG_REV}))
      else $error("more than one motion active");
  a_store_issue:
    assert property (i_WR && i_ADDR == `REG_CMD && i_WDATA[`CMD_STORE] |-> ##[1:2] o_NV_STORE)
      else $error("store command not passed on");
  a_store_pulse:
    assert property (o_NV_STORE |=> !o_NV_STORE)
      else $error("store pulse longer than one cycle");
endmodule // homing_jog_monitor

bind homing_jog_speed_table_control homing_jog_monitor #(.POS_W(POS_W), .RATE_W(RATE_W)) mon_i (
  .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .i_ADDR(i_ADDR), .i_WDATA(i_WDATA), .i_WR(i_WR),
  .o_PROG_OUTPUTS(o_PROG_OUTPUTS), .o_MODE1(o_MODE1), .o_HOMING_RUN(o_HOMING_RUN),
  .o_HOMING_DIR_REV(o_HOMING_DIR_REV), .o_HOMING_HALTED(o_HOMING_HALTED),
  .o_HOMING_RATE(o_HOMING_RATE), .o_POS_LOAD(o_POS_LOAD), .o_POS_LOAD_VALUE(o_POS_LOAD_VALUE),
  .o_JOG_FWD(o_JOG_FWD), .o_JOG_REV(o_JOG_REV), .o_NV_STORE(o_NV_STORE));

// file: verification/opto_field_model.sv
// Field-side model of the switches and sensors behind the opto inputs
`timescale 1ns/1ps
module opto_field_model (
  input wire clk,
  input wire [8:0] act,
  input wire [31:0] cfg,
  output logic [8:0] opto
);
  // Each wire follows its request through its polarity; under a forced
  // setting the wire toggles every cycle, so the block must ignore it
  initial opto = 9'h000;
  always @(posedge clk) begin
    for (int k = 0; k < 9; k++) begin
      opto[k] <= cfg[2*k+3] ? ~opto[k] : act[k] ^ cfg[2*k+2];
    end
  end
endmodule // opto_field_model

// file: verification/homing_jog_speed_table_control_tb_top.sv
// Self-checking testbench for the homing and jog speed table control block
`timescale 1ns/1ps
`include "homing_jog_defs.vh"
module homing_jog_speed_table_control_tb_top;
  localparam logic [63:0] MA = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] MN = 64'hffff_ffff_ffff_fff7;
  localparam logic [63:0] MF = 64'h0000_0000_0000_003f;
  localparam logic [31:0] SM = 32'h0000_01e1;
  localparam logic [63:0] MS = 64'h0c00_0000_0000_003f;
  logic I_SYS_CLK = 1'b0;
  logic I_SRST = 1'b1;
  logic [5:0] a = 6'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic wr = 1'b0, rd = 1'b0, pc = 1'b0, nvd = 1'b0, peek = 1'b0, rd_q = 1'b0;
  logic [4:0] zone = 5'h00;
  logic [8:0] act = 9'h000;
  logic [8:0] opto;
  logic [31:0] cfg = 32'h0000_0000;
  logic [31:0] rdata;
  logic [4:0] prog;
  logic m1, run, hlt, done, fwd, rev;
  logic nvst;
  logic [1:0] stp;
  logic [431:0] nvdat;
  logic [26:0] speed;
  logic [26:0] spd [16];
  logic [63:0] q_exp [$];
  logic [63:0] q_msk [$];
  logic [63:0] obs;
  int errors = 0, comparisons = 0, cyc = 0;
  assign obs = {24'h0, stp, speed, prog, fwd, rev, done, hlt, run, m1};
  always #2 I_SYS_CLK = ~I_SYS_CLK;

  homing_jog_speed_table_control homing_jog_speed_table_control_i (
    .I_SYS_CLK(I_SYS_CLK), .I_SRST(I_SRST), .i_ADDR(a), .i_WDATA(wd), .i_WR(wr), .i_RD(rd),
    .o_RDATA(rdata), .i_MODE_OPTO(opto[0]), .i_HOME_OPTO(opto[1]), .i_DECEL_OPTO(opto[2]),
    .i_JOG_FWD_OPTO(opto[3]), .i_JOG_REV_OPTO(opto[4]), .i_SPEED_SEL_OPTO(opto[8:5]),
    .i_PHASE_C(pc), .i_ZONE_SIGNALS(zone), .i_NV_DONE(nvd), .o_PROG_OUTPUTS(prog),
    .o_MODE1(m1), .o_HOMING_RUN(run), .o_HOMING_DIR_REV(), .o_HOMING_HALTED(hlt),
    .o_HOMING_DONE(done), .o_HOMING_STEP(stp), .o_HOMING_RATE(), .o_POS_LOAD(),
    .o_POS_LOAD_VALUE(), .o_JOG_FWD(fwd), .o_JOG_REV(rev), .o_JOG_SPEED(speed),
    .o_NV_STORE(nvst), .o_NV_DATA(nvdat));
  opto_field_model opto_field_model_i (.clk(I_SYS_CLK), .act(act), .cfg(cfg), .opto(opto));

  // ****************************************
  // Result watcher and run limit
  // ****************************************
  task check(input string n, input logic [63:0] got);
    logic [63:0] e, k;
    e = q_exp.pop_front();
    k = q_msk.pop_front();
    comparisons++;
    if (((got ^ e) & k) !== 64'h0) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e & k, got & k);
    end
  endtask
  always @(posedge I_SYS_CLK) begin
    rd_q <= rd;
    if (rd_q) check("read data", {32'h0, rdata});
    if (peek) check("outputs", obs);
    if (nvst) check("store data", {10'h0, nvdat[431:405], nvdat[26:0]});
    cyc++;
    if (cyc == 30000) begin
      errors++;
      close_out();
    end
  end

  // ****************************************
  // Drivers
  // ****************************************
  task idle(input int n);
    repeat (n) @(posedge I_SYS_CLK);
  endtask
  task wr_reg(input logic [5:0] ad, input logic [31:0] d);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    idle(1);
    wr <= 1'b0;
    idle(1);
  endtask
  task rd_reg(input logic [5:0] ad, input logic [31:0] e, input logic [31:0] k);
    q_exp.push_back({32'h0, e});
    q_msk.push_back({32'h0, k});
    a <= ad;
    rd <= 1'b1;
    idle(1);
    rd <= 1'b0;
    idle(1);
  endtask
  task pk(input logic [63:0] e, input logic [63:0] k);
    q_exp.push_back(e);
    q_msk.push_back(k);
    peek <= 1'b1;
    idle(1);
    peek <= 1'b0;
    idle(1);
  endtask
  task cfg_w(input logic [31:0] c);
    cfg <= c;
    wr_reg(`REG_CFG0, c);
  endtask
  function automatic logic [63:0] ob(input logic [26:0] s, input logic [5:0] f);
    return {26'h0, s, 5'h00, f};
  endfunction
  task close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(37));
    idle(16);
    I_SRST <= 1'b0;
    idle(1);
    rd_reg(`REG_CFG0, 32'h0000_0000, 32'hffff_ffff);
    rd_reg(6'h08, 32'h0000_0000, 32'hffff_ffff);
    rd_reg(`REG_JOG_BASE, 32'h0000_03e8, 32'hffff_ffff);
    pk(ob(`SPEED_DEFAULT, 6'h09), MA);
    for (int p = 0; p < 4; p++) begin
      for (int v = 0; v < 2; v++) begin
        act[0] <= v[0];
        cfg_w(32'(p << 2));
        idle(6);
        rd_reg(`REG_STATUS, 32'(p == 3 || (p < 2 && v == 0)), 32'h0000_0001);
      end
    end
    act <= 9'h000;
    cfg_w(32'h0000_00ac);
    idle(6);
    rd_reg(`REG_STATUS, 32'h0000_0006, 32'h0000_0006);
    cfg_w(32'h0000_02fc);
    idle(6);
    rd_reg(`REG_STATUS, 32'h0000_0008, 32'h0000_000e);
    pk(ob(`SPEED_DEFAULT, 6'h21), MN);
    cfg_w(32'h0000_0afc);
    idle(6);
    pk(ob(`SPEED_DEFAULT, 6'h01), MN);
    for (int k = 0; k < 16; k++) begin
      spd[k] = 27'($urandom_range(`SPEED_MAX, 1));
      wr_reg(`REG_JOG_BASE + 6'(k), {5'h00, spd[k]});
    end
    wr_reg(`REG_JOG_BASE, 32'h0000_0000);
    spd[0] = `SPEED_MIN;
    wr_reg(`REG_JOG_BASE + 6'h0f, 32'hffff_ffff);
    spd[15] = `SPEED_MAX;
    for (int k = 0; k < 16; k++) rd_reg(`REG_JOG_BASE + 6'(k), {5'h00, spd[k]}, 32'hffff_ffff);
    rd_reg(`REG_NV_STATUS, 32'h0000_0001, 32'h0000_0001);
    q_exp.push_back({10'h0, spd[15], spd[0]});
    q_msk.push_back(MA);
    wr_reg(`REG_CMD, 32'h0000_0002);
    nvd <= 1'b1;
    idle(1);
    nvd <= 1'b0;
    idle(2);
    rd_reg(`REG_NV_STATUS, 32'h0000_0000, 32'h0000_0001);
    act <= 9'h008;
    cfg_w(32'h0000_000c | (32'($urandom & 32'h55) << 12));
    for (int k = 0; k < 16; k++) begin
      act[8:5] <= 4'(k);
      idle(6);
      pk(ob(spd[k], 6'h21), MN);
    end
    act[4:3] <= 2'h2;
    cfg_w(32'h000c_200c);
    act[8:5] <= 4'h8;
    idle(6);
    pk(ob(spd[1], 6'h11), MN);
    act <= 9'h000;
    zone <= 5'($urandom);
    cfg_w(32'h0000_000d);
    idle(3);
    pk({53'h0, zone, 6'h00}, 64'h0000_0000_0000_07c0);
    cfg_w(32'h0000_000c);
    idle(3);
    pk(64'h0, 64'h0000_0000_0000_07c0);
    wr_reg(`REG_CFG1, 32'h0000_0000);
    wr_reg(`REG_CMD, 32'h0000_0001);
    idle(2);
    rd_reg(`REG_STATUS, 32'h0000_0021, SM);
    wr_reg(`REG_CFG1, 32'h0000_0005);
    wr_reg(`REG_HOME_POS, 32'h0fff_fffb);
    wr_reg(`REG_ACCEL, 32'h0000_0064);
    wr_reg(`REG_DECEL, 32'h0000_0028);
    wr_reg(`REG_CMD, 32'h0000_0001);
    idle(2);
    act[1] <= 1'b1;
    idle(6);
    act[2] <= 1'b1;
    idle(6);
    rd_reg(`REG_STATUS, 32'h0000_0101, SM);
    act[1] <= 1'b0;
    idle(6);
    rd_reg(`REG_STATUS, 32'h0000_0141, SM);
    act[1] <= 1'b1;
    idle(6);
    rd_reg(`REG_STATUS, 32'h0000_0101, SM);
    pk({24'h0, 2'h2, 38'h03}, MS);
    pc <= 1'b1;
    idle(4);
    pc <= 1'b0;
    idle(4);
    rd_reg(`REG_STATUS, 32'h0000_0021, 32'h0000_0061);
    pk(ob(27'h0, 6'h09), MF);
    act <= 9'h000;
    wr_reg(`REG_CMD, 32'h0000_0001);
    idle(2);
    act[1] <= 1'b1;
    idle(6);
    act[1] <= 1'b0;
    idle(6);
    rd_reg(`REG_STATUS, 32'h0000_00c1, SM);
    act[3] <= 1'b1;
    idle(6);
    rd_reg(`REG_STATUS, 32'h0000_0001, SM);
    pk(ob(27'h0, 6'h21), MF);
    // Decel-only and phase-C-only methods, each from a fresh reset command
    for (int mth = 2; mth < 4; mth++) begin
      act <= 9'h000;
      wr_reg(`REG_CFG1, 32'(mth));
      wr_reg(`REG_CMD, 32'h0000_0001);
      idle(2);
      act[1] <= 1'b1;
      idle(6);
      rd_reg(`REG_STATUS, (mth == 2) ? 32'h0000_0081 : 32'h0000_0101, SM);
      act[2] <= (mth == 2);
      pc <= (mth == 3);
      idle(8);
      rd_reg(`REG_STATUS, 32'h0000_0021, SM);
    end
    close_out();
  end
endmodule // homing_jog_speed_table_control_tb_top
